/* logic/ddc_pkg.sv */
// ddc_pkg: register map, fields, coefficients and carrier types
package ddc_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_SYNC_CTL = 10'h100;
   localparam logic [9:0] IDX_FIR_CTL = 10'h102;
   localparam logic [9:0] IDX_HB_CTL = 10'h103;
   localparam logic [9:0] IDX_OSC_CTL = 10'h11d;
   localparam logic [9:0] IDX_TUNE_A = 10'h11e;
   localparam logic [9:0] IDX_TUNE_B = 10'h11f;
   localparam logic [9:0] IDX_TUNE_C = 10'h120;
   localparam logic [9:0] IDX_TUNE_D = 10'h121;
   localparam logic [9:0] IDX_PHASE_A = 10'h122;
   localparam logic [9:0] IDX_PHASE_B = 10'h123;
   localparam logic [9:0] IDX_OUT_CTL = 10'h124;
   localparam logic [9:0] IDX_STATUS = 10'h125;
   localparam int AXI_AW = 12;
   // field positions
   localparam int OSC_EN_BIT = 0;
   localparam int OSC_DITHER_BIT = 1;
   localparam int SYNC_NCO_EN_BIT = 3;
   localparam int SYNC_NCO_EVERY_BIT = 4;
   localparam int SYNC_HB_EN_BIT = 5;
   localparam int SYNC_HB_EVERY_BIT = 6;
   localparam int FIR_EN_BIT = 0;
   localparam int HB_HIGHPASS_BIT = 1;
   localparam int HB_REVERSE_BIT = 2;
   localparam int HB_PHASE_BIT = 3;
   localparam int OUT_FINAL_EN_BIT = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam logic [15:0] LFSR_TAPS = 16'hb400;
   // datapath shape
   localparam int DW = 16;
   localparam int HB_TAPS = 19;
   localparam int HB_PAIRS = 5;
   localparam int HB_SHIFT = 20;
   localparam int FIR_TAPS = 66;
   localparam int FIR_PAIRS = 33;
   localparam int FIR_SHIFT = 21;
   localparam int LUT_QTR = 16;
   localparam logic signed [20:0] HB_PAIR [HB_PAIRS] =
      '{21'sd844, -21'sd6189, 21'sd25080, -21'sd79170, 21'sd321584};
   localparam logic signed [20:0] HB_CENTER = 21'sd524287;
   localparam logic signed [21:0] FIR_PAIR [FIR_PAIRS] = '{
      22'sd383, 22'sd1431, 22'sd1950, 22'sd96, -22'sd2661, -22'sd1750,
      22'sd2476, 22'sd2388, -22'sd3867, -22'sd5150, 22'sd3788, 22'sd7513,
      -22'sd4511, -22'sd11914, 22'sd3650, 22'sd16484, -22'sd2818,
      -22'sd23200, -22'sd48, 22'sd30748, 22'sd3976, -22'sd41019,
      -22'sd11147, 22'sd53608, 22'sd21818, -22'sd71611, -22'sd40300,
      22'sd98830, 22'sd74264, -22'sd152696, -22'sd161248, 22'sd337056,
      22'sd922060};
   // quarter sine, 17 points
   localparam logic signed [15:0] SINE_QTR [LUT_QTR+1] = '{
      16'sd0, 16'sd3212, 16'sd6393, 16'sd9512, 16'sd12539, 16'sd15446,
      16'sd18204, 16'sd20787, 16'sd23170, 16'sd25330, 16'sd27245,
      16'sd28898, 16'sd30273, 16'sd31356, 16'sd32137, 16'sd32609,
      16'sd32767};
   typedef struct packed {
      logic awvalid;
      logic [AXI_AW-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [AXI_AW-1:0] araddr;
      logic rready;
   } ddc_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ddc_axi_rsp_t;
   typedef struct packed {
      logic [DW-1:0] data;
      logic valid;
      logic isQ;
   } ddc_sample_t;
endpackage

/* logic/ddc_core.sv */
// ddc_core: tuning oscillator, half-band, fir and final translator
`timescale 1ns/1ps
module ddc_core
   import ddc_pkg::*;
#(
   parameter int ADC_WIDTH = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // sample stream
   input wire logic [ADC_WIDTH-1:0] adcSample,
   input wire logic syncIn,
   output ddc_sample_t dataOut,
   // register bus
   input ddc_axi_req_t axiReq,
   output ddc_axi_rsp_t axiRsp
);

   if (ADC_WIDTH < 8 || ADC_WIDTH > DW) begin : g_width_check
      $error("ddc_core: ADC_WIDTH must be 8 to 16");
   end

   typedef logic [1:0][DW-1:0] ddc_iq_t;

   typedef struct packed {
      logic [7:0] syncCtl;
      logic [7:0] firCtl;
      logic [7:0] hbCtl;
      logic [7:0] oscCtl;
      logic [7:0] outCtl;
      logic [31:0] tuningWord;
      logic [15:0] phaseOffsetWord;
      logic awHeld;
      logic wHeld;
      logic [AXI_AW-1:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      ddc_axi_rsp_t rsp;
      logic ncoArmed;
      logic hbArmed;
      logic syncLast;
      logic [31:0] phaseAcc;
      logic [15:0] lfsr;
      logic revSign;
      ddc_iq_t mix;
      logic [HB_TAPS-1:0][1:0][DW-1:0] hbLine;
      logic decToggle;
      ddc_iq_t hb;
      logic hbValid;
      logic [FIR_TAPS-1:0][1:0][DW-1:0] firLine;
      logic firStep;
      ddc_iq_t fir;
      logic firValid;
      logic [1:0] rot;
      logic [DW-1:0] pendQ;
      logic pendValid;
      ddc_sample_t out;
   } ddc_state_t;

   ddc_state_t s_q;
   ddc_state_t s_d;

   // one product per mirrored tap pair and path
   logic signed [47:0] firProd [2][FIR_PAIRS];
   for (genvar p = 0; p < 2; p++) begin : g_path
      for (genvar k = 0; k < FIR_PAIRS; k++) begin : g_pair
         assign firProd[p][k] = 48'($signed(FIR_PAIR[k]) *
            ($signed(17'($signed(s_q.firLine[k][p]))) +
             $signed(17'($signed(s_q.firLine[FIR_TAPS-1-k][p])))));
      end
   end

   // coarse 64-point wave keeps the table small; spurs traded for area
   function automatic logic signed [15:0] sineOf(input logic [5:0] ph);
      logic [4:0] idx;
      logic signed [15:0] mag;
      idx = ph[4] ? 5'(LUT_QTR - int'(ph[3:0])) : {1'b0, ph[3:0]};
      mag = SINE_QTR[idx];
      return ph[5] ? -mag : mag;
   endfunction

   function automatic logic mapped(input logic [9:0] idx);
      case (idx)
         IDX_SYNC_CTL, IDX_FIR_CTL, IDX_HB_CTL, IDX_OSC_CTL,
         IDX_TUNE_A, IDX_TUNE_B, IDX_TUNE_C, IDX_TUNE_D,
         IDX_PHASE_A, IDX_PHASE_B, IDX_OUT_CTL, IDX_STATUS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] readMux(input ddc_state_t s, input logic [9:0] idx);
      case (idx)
         IDX_SYNC_CTL: return {24'h000000, s.syncCtl};
         IDX_FIR_CTL: return {24'h000000, s.firCtl};
         IDX_HB_CTL: return {24'h000000, s.hbCtl};
         IDX_OSC_CTL: return {24'h000000, s.oscCtl};
         IDX_TUNE_A: return {24'h000000, s.tuningWord[7:0]};
         IDX_TUNE_B: return {24'h000000, s.tuningWord[15:8]};
         IDX_TUNE_C: return {24'h000000, s.tuningWord[23:16]};
         IDX_TUNE_D: return {24'h000000, s.tuningWord[31:24]};
         IDX_PHASE_A: return {24'h000000, s.phaseOffsetWord[7:0]};
         IDX_PHASE_B: return {24'h000000, s.phaseOffsetWord[15:8]};
         IDX_OUT_CTL: return {24'h000000, s.outCtl};
         IDX_STATUS: return {29'h00000000, s.decToggle, s.hbArmed, s.ncoArmed};
         default: return 32'h00000000;
      endcase
   endfunction

   always_comb begin
      logic [9:0] idx;
      logic syncWrite;
      logic syncRise;
      logic ncoSync;
      logic hbSync;
      logic [15:0] ph;
      logic signed [15:0] sinV;
      logic signed [15:0] cosV;
      logic signed [ADC_WIDTH+15:0] prodI;
      logic signed [ADC_WIDTH+15:0] prodQ;
      logic signed [DW-1:0] mixI;
      logic signed [DW-1:0] mixQ;
      logic signed [47:0] acc [2];
      logic signed [DW-1:0] stI;
      logic signed [DW-1:0] stQ;
      logic stValid;
      idx = '0;
      syncWrite = 1'b0;
      syncRise = 1'b0;
      ncoSync = 1'b0;
      hbSync = 1'b0;
      ph = '0;
      sinV = '0;
      cosV = '0;
      prodI = '0;
      prodQ = '0;
      mixI = '0;
      mixQ = '0;
      acc[0] = '0;
      acc[1] = '0;
      stI = '0;
      stQ = '0;
      stValid = 1'b0;
      s_d = s_q;

      // write channel: address and data taken in either order
      if (s_q.rsp.bvalid && axiReq.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      if (axiReq.awvalid && s_q.rsp.awready) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && s_q.rsp.wready) begin
         s_d.wHeld = 1'b1;
         s_d.wData = axiReq.wdata;
         s_d.wStrb = axiReq.wstrb;
      end
      if (s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid) begin
         idx = s_q.awAddr[AXI_AW-1:2];
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = mapped(idx) ? RESP_OKAY : RESP_SLVERR;
         if (s_q.wStrb[0]) begin
            case (idx)
               IDX_SYNC_CTL: begin
                  s_d.syncCtl = s_q.wData[7:0];
                  syncWrite = 1'b1;
               end
               IDX_FIR_CTL: s_d.firCtl = s_q.wData[7:0];
               IDX_HB_CTL: s_d.hbCtl = s_q.wData[7:0];
               IDX_OSC_CTL: s_d.oscCtl = s_q.wData[7:0];
               IDX_TUNE_A: s_d.tuningWord[7:0] = s_q.wData[7:0];
               IDX_TUNE_B: s_d.tuningWord[15:8] = s_q.wData[7:0];
               IDX_TUNE_C: s_d.tuningWord[23:16] = s_q.wData[7:0];
               IDX_TUNE_D: s_d.tuningWord[31:24] = s_q.wData[7:0];
               IDX_PHASE_A: s_d.phaseOffsetWord[7:0] = s_q.wData[7:0];
               IDX_PHASE_B: s_d.phaseOffsetWord[15:8] = s_q.wData[7:0];
               IDX_OUT_CTL: s_d.outCtl = s_q.wData[7:0];
               default: s_d.outCtl = s_q.outCtl;
            endcase
         end
      end
      s_d.rsp.awready = !s_d.awHeld;
      s_d.rsp.wready = !s_d.wHeld;

      // read channel
      if (s_q.rsp.rvalid && axiReq.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      if (axiReq.arvalid && s_q.rsp.arready) begin
         idx = axiReq.araddr[AXI_AW-1:2];
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata = readMux(s_q, idx);
         s_d.rsp.rresp = mapped(idx) ? RESP_OKAY : RESP_SLVERR;
      end
      s_d.rsp.arready = !s_d.rsp.rvalid;

      // sync: a register write re-arms, and wins over a same-cycle pulse
      syncRise = syncIn && !s_q.syncLast;
      s_d.syncLast = syncIn;
      ncoSync = syncRise && s_q.syncCtl[SYNC_NCO_EN_BIT] &&
         (s_q.syncCtl[SYNC_NCO_EVERY_BIT] || s_q.ncoArmed);
      hbSync = syncRise && s_q.syncCtl[SYNC_HB_EN_BIT] &&
         (s_q.syncCtl[SYNC_HB_EVERY_BIT] || s_q.hbArmed);
      if (ncoSync) begin
         s_d.ncoArmed = 1'b0;
      end
      if (hbSync) begin
         s_d.hbArmed = 1'b0;
      end
      if (syncWrite) begin
         s_d.ncoArmed = 1'b1;
         s_d.hbArmed = 1'b1;
      end

      // oscillator; wrap of the unsigned sum is the signed frequency
      s_d.phaseAcc = ncoSync ? 32'h00000000 : s_q.phaseAcc + s_q.tuningWord;
      s_d.lfsr = s_q.lfsr[0] ? (s_q.lfsr >> 1) ^ LFSR_TAPS : s_q.lfsr >> 1;
      ph = s_q.phaseAcc[31:16] + s_q.phaseOffsetWord;
      sinV = sineOf(ph[15:10]);
      cosV = sineOf(6'(ph[15:10] + 6'(LUT_QTR)));
      if (s_q.oscCtl[OSC_DITHER_BIT]) begin
         sinV = sinV - 16'(s_q.lfsr[0]);
         cosV = cosV - 16'(s_q.lfsr[1]);
      end

      // mixer, both paths fed from the one oscillator
      if (s_q.oscCtl[OSC_EN_BIT]) begin
         prodI = $signed(adcSample) * cosV;
         prodQ = -($signed(adcSample) * sinV);
         mixI = prodI[ADC_WIDTH+14 -: DW];
         mixQ = prodQ[ADC_WIDTH+14 -: DW];
      end else begin
         prodI = (ADC_WIDTH+16)'($signed(adcSample)) <<< 16;
         mixI = prodI[ADC_WIDTH+15 -: DW];
         mixQ = '0;
      end
      s_d.revSign = !s_q.revSign;
      if (s_q.hbCtl[HB_REVERSE_BIT] && s_q.revSign) begin
         mixI = -mixI;
         mixQ = -mixQ;
      end
      s_d.mix = {mixQ, mixI};

      // half-band: compute every second sample; after a sync never twice in a row, or a Q is lost
      s_d.hbLine[0] = s_q.mix;
      for (int k = 1; k < HB_TAPS; k++) begin
         s_d.hbLine[k] = s_q.hbLine[k-1];
      end
      s_d.decToggle = hbSync ? s_q.hbCtl[HB_PHASE_BIT] : !s_q.decToggle;
      s_d.hbValid = 1'b0;
      if (!s_q.decToggle && !s_q.hbValid) begin
         for (int p = 0; p < 2; p++) begin
            acc[p] = '0;
            for (int k = 0; k < HB_PAIRS; k++) begin
               acc[p] = acc[p] + 48'($signed(HB_PAIR[k]) *
                  ($signed(17'($signed(s_q.hbLine[2*k][p]))) +
                   $signed(17'($signed(s_q.hbLine[HB_TAPS-1-2*k][p])))));
            end
            // high-pass flips odd taps, and only the centre is odd
            if (s_q.hbCtl[HB_HIGHPASS_BIT]) begin
               acc[p] = acc[p] - 48'($signed(HB_CENTER) * $signed(s_q.hbLine[9][p]));
            end else begin
               acc[p] = acc[p] + 48'($signed(HB_CENTER) * $signed(s_q.hbLine[9][p]));
            end
            s_d.hb[p] = acc[p][HB_SHIFT +: DW];
         end
         s_d.hbValid = 1'b1;
      end

      // fir at the decimated rate; no decimation here
      s_d.firStep = 1'b0;
      if (s_q.hbValid) begin
         s_d.firLine[0] = s_q.hb;
         for (int k = 1; k < FIR_TAPS; k++) begin
            s_d.firLine[k] = s_q.firLine[k-1];
         end
         s_d.firStep = 1'b1;
      end
      s_d.firValid = s_q.firStep;
      if (s_q.firStep) begin
         for (int p = 0; p < 2; p++) begin
            acc[p] = '0;
            for (int k = 0; k < FIR_PAIRS; k++) begin
               acc[p] = acc[p] + firProd[p][k];
            end
            s_d.fir[p] = acc[p][FIR_SHIFT +: DW];
         end
      end

      // half-band is never off, so fir enable alone decides
      if (s_q.firCtl[FIR_EN_BIT]) begin
         stValid = s_q.firValid;
         stI = s_q.fir[0];
         stQ = s_q.fir[1];
      end else begin
         stValid = s_q.hbValid;
         stI = s_q.hb[0];
         stQ = s_q.hb[1];
      end

      // final translator: quarter turn per decimated sample
      s_d.out.valid = 1'b0;
      s_d.out.isQ = 1'b0;
      if (s_q.outCtl[OUT_FINAL_EN_BIT]) begin
         s_d.pendValid = 1'b0;
         if (stValid) begin
            case (s_q.rot)
               2'h0: s_d.out.data = stI;
               2'h1: s_d.out.data = -stQ;
               2'h2: s_d.out.data = -stI;
               2'h3: s_d.out.data = stQ;
               default: s_d.out.data = stI;
            endcase
            s_d.out.valid = 1'b1;
            s_d.rot = s_q.rot + 2'h1;
         end
      end else if (stValid) begin
         s_d.out.data = stI;
         s_d.out.valid = 1'b1;
         s_d.pendQ = stQ;
         s_d.pendValid = 1'b1;
      end else if (s_q.pendValid) begin
         s_d.out.data = s_q.pendQ;
         s_d.out.valid = 1'b1;
         s_d.out.isQ = 1'b1;
         s_d.pendValid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.syncCtl <= CTL_RESET;
         s_q.firCtl <= CTL_RESET;
         s_q.hbCtl <= CTL_RESET;
         s_q.oscCtl <= CTL_RESET;
         s_q.outCtl <= CTL_RESET;
         s_q.lfsr <= LFSR_SEED;
         s_q.rsp.awready <= 1'b1;
         s_q.rsp.wready <= 1'b1;
         s_q.rsp.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign dataOut = s_q.out;
   assign axiRsp = s_q.rsp;

endmodule // ddc_core

/* tb/ddc_checker.sv */
// ddc_checker: bus handshake and output stream assertions for ddc_core
`timescale 1ns/1ps
module ddc_checker
   import ddc_pkg::*;
#(
   parameter int ADC_WIDTH = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // sample stream
   input wire logic [ADC_WIDTH-1:0] adcSample,
   input wire logic syncIn,
   input ddc_sample_t dataOut,
   // register bus
   input ddc_axi_req_t axiReq,
   input ddc_axi_rsp_t axiRsp
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence wrBoth;
      axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
   endsequence
   sequence rdTaken;
      axiReq.arvalid && axiRsp.arready;
   endsequence

   a_write_answer: assert property (wrBoth |-> ##[1:2] axiRsp.bvalid)
      else $error("write response late");
   a_aw_refused: assert property (wrBoth |=> !axiRsp.awready && !axiRsp.wready)
      else $error("write channels ready while a write is held");
   a_read_answer: assert property (rdTaken |=> axiRsp.rvalid && !axiRsp.arready)
      else $error("read data not one cycle after address");
   a_bresp_stands: assert property (axiRsp.bvalid && !axiReq.bready |=>
      axiRsp.bvalid && $stable(axiRsp.bresp))
      else $error("write response dropped before bready");
   a_rdata_stands: assert property (axiRsp.rvalid && !axiReq.rready |=>
      axiRsp.rvalid && $stable(axiRsp.rdata))
      else $error("read data dropped before rready");
   a_ar_refused: assert property (axiRsp.rvalid |-> !axiRsp.arready)
      else $error("read address ready while data pending");
   a_reset_idle: assert property ($rose(reset_n) |->
      axiRsp.awready && axiRsp.arready && !axiRsp.bvalid && !dataOut.valid)
      else $error("outputs not idle after reset");
   a_q_after_i: assert property (dataOut.valid && dataOut.isQ |->
      $past(dataOut.valid) && !$past(dataOut.isQ))
      else $error("quadrature sample without its in-phase partner");
   a_decimate: assert property (dataOut.valid && !dataOut.isQ |=>
      !(dataOut.valid && !dataOut.isQ))
      else $error("in-phase or real samples on consecutive clocks");
   a_data_holds: assert property (!dataOut.valid |-> $stable(dataOut.data))
      else $error("output data moved without valid");
endmodule // ddc_checker

bind ddc_core ddc_checker #(.ADC_WIDTH(ADC_WIDTH)) i_checker (.clk(clk), .reset_n(reset_n),
   .adcSample(adcSample), .syncIn(syncIn), .dataOut(dataOut), .axiReq(axiReq),
   .axiRsp(axiRsp));

/* tb/ddc_adc_model.sv */
// ddc_adc_model: sample source, sync pin and output capture around ddc_core
`timescale 1ns/1ps
module ddc_adc_model
   import ddc_pkg::*;
#(
   parameter int ADC_WIDTH = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // bench control
   input wire logic [ADC_WIDTH-1:0] level,
   input wire logic syncLevel,
   // device side
   output logic [ADC_WIDTH-1:0] adcSample,
   output logic syncIn,
   input ddc_sample_t dataOut,
   // captured output, hist[0] newest
   output logic [DW-1:0] lastQ,
   output logic [3:0][DW-1:0] hist
);
   // converter hands over a fresh sample every clock, no idle cycles
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         adcSample <= '0;
         syncIn <= 1'h0;
         lastQ <= '0;
         hist <= '0;
      end else begin
         adcSample <= level;
         syncIn <= syncLevel;
         if (dataOut.valid && dataOut.isQ) begin
            lastQ <= dataOut.data;
         end
         // in-phase valid is a one-cycle pulse, so capture on the same edge
         if (dataOut.valid && !dataOut.isQ) begin
            hist <= {hist[2:0], dataOut.data};
         end
      end
   end
endmodule // ddc_adc_model

/* tb/tb_top.sv */
// tb_top: register, filter, mixer and sync tests for ddc_core
`timescale 1ns/1ps
module tb_top
   import ddc_pkg::*;
;
   localparam int AW = 12;
   logic clk;
   logic reset_n;
   logic [AW-1:0] level;
   logic syncLevel;
   logic [AW-1:0] adcSample;
   logic syncIn;
   ddc_sample_t dataOut;
   ddc_axi_req_t req;
   ddc_axi_rsp_t rsp;
   logic [15:0] lastQ;
   logic [3:0][15:0] hist;
   logic [31:0] rd;
   logic [1:0] resp;
   int errors;
   int comparisons;
   int n [2];
   longint hbSum;
   longint firSum;
   longint lpOut;
   longint firOut;
   longint g;
   logic [9:0] ctlIdx [5] = '{IDX_SYNC_CTL, IDX_FIR_CTL, IDX_HB_CTL, IDX_OSC_CTL, IDX_OUT_CTL};
   logic [7:0] hbCtl [3] = '{8'h00, 8'h02, 8'h06};
   logic [15:0] phases [3] = '{16'h0000, 16'h4000, 16'h2000};

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   ddc_core #(.ADC_WIDTH(AW)) i_dut (.clk(clk), .reset_n(reset_n), .adcSample(adcSample),
      .syncIn(syncIn), .dataOut(dataOut), .axiReq(req), .axiRsp(rsp));
   ddc_adc_model #(.ADC_WIDTH(AW)) i_adc (.clk(clk), .reset_n(reset_n), .level(level),
      .syncLevel(syncLevel), .adcSample(adcSample), .syncIn(syncIn), .dataOut(dataOut),
      .lastQ(lastQ), .hist(hist));

   task automatic final_report();
      if (errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang();
      errors++;
      $display("FAIL %0t wait ran out", $time);
      final_report();
   endtask

   function automatic logic [31:0] abs16(input logic [15:0] d);
      return {16'h0, d[15] ? 16'(-d) : d};
   endfunction

   // gain then an arithmetic shift, which floors like the datapath
   function automatic longint scale(input longint x, input longint gain, input int sh);
      return (x * gain) >>> sh;
   endfunction

   task automatic axiWrite(input logic [9:0] idx, input logic [7:0] val);
      @(posedge clk);
      req.awvalid <= 1'h1;
      req.awaddr <= {idx, 2'h0};
      req.wvalid <= 1'h1;
      req.wdata <= {24'h0, val};
      req.wstrb <= 4'hf;
      req.bready <= 1'h1;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
         if (rsp.bvalid) begin
            resp = rsp.bresp;
            req.bready <= 1'h0;
            return;
         end
      end
      hang();
   endtask

   task automatic axiRead(input logic [9:0] idx);
      @(posedge clk);
      req.arvalid <= 1'h1;
      req.araddr <= {idx, 2'h0};
      req.rready <= 1'h1;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
         if (rsp.rvalid) begin
            rd = rsp.rdata;
            resp = rsp.rresp;
            req.rready <= 1'h0;
            return;
         end
      end
      hang();
   endtask

   // the longest path is the fir line at half rate, so settle well past it
   task automatic cfg(input logic [7:0] osc, fir, hb, outc);
      axiWrite(IDX_OSC_CTL, osc);
      axiWrite(IDX_FIR_CTL, fir);
      axiWrite(IDX_HB_CTL, hb);
      axiWrite(IDX_OUT_CTL, outc);
      repeat (200) @(posedge clk);
   endtask

   initial begin
      errors = 0;
      comparisons = 0;
      reset_n = 1'h0;
      req = '0;
      level = 12'h064;
      syncLevel = 1'h0;
      hbSum = 0;
      firSum = 0;
      foreach (HB_PAIR[i]) hbSum += 2 * longint'(HB_PAIR[i]);
      foreach (FIR_PAIR[i]) firSum += 2 * longint'(FIR_PAIR[i]);
      lpOut = (longint'(1600) * (hbSum + longint'(HB_CENTER))) >>> 20;
      firOut = (lpOut * firSum) >>> 21;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      foreach (ctlIdx[i]) begin
         axiRead(ctlIdx[i]);
         check(rd, {24'h0, CTL_RESET});
      end
      // tuning bytes then phase bytes, contiguous indices
      for (int i = 0; i < 6; i++) begin
         axiWrite(IDX_TUNE_A + 10'(i), 8'h11 * 8'(i + 1));
         check(32'(resp), 32'(RESP_OKAY));
         axiRead(IDX_TUNE_A + 10'(i));
         check(rd, {24'h0, 8'h11 * 8'(i + 1)});
      end
      axiWrite(10'h101, 8'hff);
      check(32'(resp), 32'(RESP_SLVERR));
      axiRead(10'h101);
      check(rd, 32'h0);
      check(32'(resp), 32'(RESP_SLVERR));
      // first-only sync: write arms, one pulse disarms
      axiWrite(IDX_SYNC_CTL, 8'h28);
      axiRead(IDX_STATUS);
      check(rd & 32'h3, 32'h3);
      @(posedge clk);
      syncLevel <= 1'h1;
      repeat (4) @(posedge clk);
      syncLevel <= 1'h0;
      axiRead(IDX_STATUS);
      check(rd & 32'h3, 32'h0);
      // dc through the half-band with the oscillator bypassed
      for (int i = 0; i < 3; i++) begin
         cfg(8'h00, 8'h00, hbCtl[i], 8'h00);
         // reversal may leave the output negative, and the shift floors it
         g = hbSum + (i == 1 ? -1 : 1) * longint'(HB_CENTER);
         check({16'h0, hist[0]}, {16'h0, 16'(scale(hist[0][15] ? -1600 : 1600, g,
            20))});
         check(32'(lastQ), 32'h0);
      end
      cfg(8'h00, 8'h01, 8'h00, 8'h00);
      check(32'(hist[0]), 32'(firOut));
      cfg(8'h00, 8'h01, 8'h00, 8'h01);
      check({16'h0, hist[0] + hist[2]}, 32'h0);
      check({16'h0, hist[1] + hist[3]}, 32'h0);
      check(abs16(hist[0]) + abs16(hist[1]), 32'(firOut));
      // oscillator at dc: a sync zeroes the accumulator, the offset alone sets the angle
      for (int i = 0; i < 4; i++) axiWrite(IDX_TUNE_A + 10'(i), 8'h00);
      axiWrite(IDX_SYNC_CTL, 8'h08);
      syncLevel <= 1'h1;
      repeat (4) @(posedge clk);
      syncLevel <= 1'h0;
      g = hbSum + longint'(HB_CENTER);
      for (int i = 0; i < 3; i++) begin
         axiWrite(IDX_PHASE_A, phases[i][7:0]);
         axiWrite(IDX_PHASE_B, phases[i][15:8]);
         cfg(8'h01, 8'h00, 8'h00, 8'h00);
         check({31'h0, hist[0] === 16'h0}, {31'h0, i == 1});
         check({31'h0, lastQ === 16'h0}, {31'h0, i == 0});
         if (i == 2) begin
            check({16'h0, hist[0]}, {16'h0, 16'(scale(scale(longint'(level) *
               longint'(SINE_QTR[8]), 1, AW - 1), g, 20))});
            check({16'h0, lastQ}, {16'h0, 16'(scale(scale(-longint'(level) *
               longint'(SINE_QTR[8]), 1, AW - 1), g, 20))});
         end
      end
      // dither at a quarter turn: the zero cosine picks up a random lsb
      axiWrite(IDX_PHASE_B, 8'h40);
      cfg(8'h03, 8'h00, 8'h00, 8'h00);
      n[0] = 0;
      repeat (40) begin
         @(posedge clk);
         if (dataOut.valid && !dataOut.isQ && dataOut.data !== 16'h0) n[0]++;
      end
      check(32'(n[0] > 0), 32'h1);
      // minus half the clock: cosine flips each sample, low-pass kills it
      axiWrite(IDX_PHASE_B, 8'h00);
      axiWrite(IDX_TUNE_D, 8'h80);
      repeat (200) @(posedge clk);
      check({31'h0, abs16(hist[0]) <= 32'h1}, 32'h1);
      check(32'(lastQ), 32'h0);
      // decimation phase moves output by one input clock after sync
      for (int p = 0; p < 2; p++) begin
         cfg(8'h00, 8'h00, 8'(p << 3), 8'h00);
         axiWrite(IDX_SYNC_CTL, 8'h78);
         syncLevel <= 1'h1;
         repeat (12) @(posedge clk);
         n[p] = 12;
         do begin
            @(posedge clk);
            n[p]++;
         end while (!(dataOut.valid && !dataOut.isQ) && n[p] < 40);
         if (n[p] >= 40) hang();
         syncLevel <= 1'h0;
      end
      check(32'((n[1] - n[0]) & 1), 32'h1);
      final_report();
   end
endmodule // tb_top
